// file: logic/rte_pkg.sv
package rte_pkg;

  // ****************************************************
  // Register offsets
  // ****************************************************
  localparam logic [7:0] REG_CDR_RST    = 8'h0A;
  localparam logic [7:0] REG_EYE_CFG    = 8'h11;
  localparam logic [7:0] REG_TAP1       = 8'h12;
  localparam logic [7:0] REG_MAN_TAP    = 8'h15;
  localparam logic [7:0] REG_SLEW       = 8'h18;
  localparam logic [7:0] REG_DFE_PWR    = 8'h1E;
  localparam logic [7:0] REG_POLARITY   = 8'h1F;
  localparam logic [7:0] REG_TAP23      = 8'h20;
  localparam logic [7:0] REG_TAP45      = 8'h21;
  localparam logic [7:0] REG_EYE_OVR    = 8'h22;
  localparam logic [7:0] REG_TAP_OVR    = 8'h23;
  localparam logic [7:0] REG_FAST_EYE   = 8'h24;
  localparam logic [7:0] REG_EYE_UP     = 8'h25;
  localparam logic [7:0] REG_EYE_LO     = 8'h26;
  localparam logic [7:0] REG_ACC_TIME   = 8'h2A;
  localparam logic [7:0] REG_RATE_ADAPT = 8'h2F;
  localparam logic [7:0] REG_ADAPT_MODE = 8'h31;
  localparam logic [7:0] REG_LOCK_MON   = 8'h3E;
  localparam logic [7:0] REG_OBS_ONE    = 8'h71;
  localparam logic [7:0] REG_OBS_TWO    = 8'h72;
  localparam logic [7:0] REG_OBS_THREE  = 8'h73;
  localparam logic [7:0] REG_OBS_FOUR   = 8'h74;
  localparam logic [7:0] REG_OBS_FIVE   = 8'h75;
  localparam logic [7:0] REG_CH_SEL     = 8'hFF;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_EYE_CFG    = 8'h20;
  localparam logic [7:0] RST_DFE_PWR    = 8'h08;
  localparam logic [7:0] RST_TAP_OVR    = 8'h40;
  localparam logic [7:0] RST_LOCK_MON   = 8'h80;
  localparam logic [7:0] RST_ADAPT_MODE = 8'h20;
  localparam logic [7:0] RST_ACC_TIME   = 8'hFF;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int BIT_EYE_PD    = 5;
  localparam int BIT_RANGE_LO  = 6;
  localparam int BIT_TAP1_SIGN = 7;
  localparam int BIT_MAN_TAP   = 7;
  localparam int BIT_SLOW_SLEW = 2;
  localparam int BIT_FEEDBACK_EQ_POWERDOWN    = 3;
  localparam int BIT_INVERT    = 7;
  localparam int BIT_EYE_OVR   = 7;
  localparam int BIT_TAP_OVR   = 6;
  localparam int BIT_FAST_EN   = 7;
  localparam int BIT_DFE_TRIG  = 2;
  localparam int BIT_SWEEP     = 1;
  localparam int BIT_CTLE_TRIG = 0;
  localparam int BIT_MODE_LO   = 5;
  localparam int BIT_CDR_LO    = 2;
  localparam int BIT_LOCK_MON  = 7;
  localparam int BIT_CH_EN     = 2;

  // ****************************************************
  // Eye sweep and range constants
  // ****************************************************
  localparam logic [12:0] EYE_TOTAL_PTS = 13'h1002;
  localparam logic [15:0] EYE_CNT_MAX   = 16'hFFFF;
  localparam int          ACC_SHIFT_DEF = 10;
  localparam logic [8:0]  RANGE_MV_0    = 9'h064;
  localparam logic [8:0]  RANGE_MV_1    = 9'h0C8;
  localparam logic [8:0]  RANGE_MV_2    = 9'h12C;
  localparam logic [8:0]  RANGE_MV_3    = 9'h190;
  localparam logic [1:0]  MODE_DFE_MIN  = 2'h2;
  localparam int          TAP_W         = 26;

  // Two-wire slave states
  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b000,
    BUS_ADDR  = 3'b001,
    BUS_ACK_A = 3'b010,
    BUS_WBYTE = 3'b011,
    BUS_ACK_W = 3'b100,
    BUS_RDATA = 3'b101,
    BUS_MACK  = 3'b110
  } rte_bus_t;

endpackage

// file: logic/rte_eye_tap_ctrl.sv
`timescale 1ns/1ns
module rte_eye_tap_ctrl
  import rte_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR  = 7'h18,
  parameter logic [1:0] CH_ID     = 2'h0,
  parameter int         ACC_SHIFT = ACC_SHIFT_DEF
) (
  input  wire logic              CLK_IN,
  input  wire logic              RST_IN,
  input  wire logic              SCL_IN,
  input  wire logic              SDA_IN,
  output logic                   SDA_OUT,
  output logic                   SDA_OE_OUT,
  input  wire logic              EYE_HIT_IN,
  input  wire logic              PERIODIC_POWER_IN,
  input  wire logic              SIGNAL_DETECT_IN,
  input  wire logic              LOCK_IN,
  input  wire logic              ADAPT_DONE_IN,
  input  wire logic              ADAPT_BETTER_IN,
  input  wire logic [TAP_W-1:0]  ADAPT_TAPS_IN,
  output logic [8:0]             EYE_RANGE_MV_OUT,
  output logic                   EYE_POWER_OUT,
  output logic                   LOCK_MON_EN_OUT,
  output logic                   EYE_OVR_OUT,
  output logic                   FAST_EYE_OUT,
  output logic [5:0]             EYE_PHASE_OUT,
  output logic [5:0]             EYE_VOLT_OUT,
  output logic                   TAP_OVR_OUT,
  output logic                   FEEDBACK_EQ_POWERDOWN_OUT,
  output logic [TAP_W-1:0]       DFE_TAPS_OUT,
  output logic                   DFE_ADAPT_OUT,
  output logic                   CTLE_ADAPT_OUT,
  output logic                   CDR_RESET_OUT,
  output logic                   OUT_INVERT_OUT,
  output logic                   SLOW_SLEW_OUT,
  output logic [1:0]             ADAPT_MODE_OUT
);

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic             scl_s1, scl_s2, scl_s3;
    logic             sda_s1, sda_s2, sda_s3;
    logic             sig_s1, sig_s2, sig_s3;
    rte_bus_t         st;
    logic [3:0]       bitc;
    logic [7:0]       shreg;
    logic             rw;
    logic             got_ptr;
    logic             nack;
    logic [7:0]       ptr;
    logic             sda_oe;
    logic [7:0]       r0a, r11, r12, r15, r18, r1e, r1f, r20, r21;
    logic [7:0]       r22, r23, r24, r2a, r2f, r31, r3e, rff;
    logic [18:0]      tcnt;
    logic [15:0]      acc;
    logic [15:0]      cur;
    logic [7:0]       lsb;
    logic             lo_pend;
    logic [12:0]      pidx;
    logic [TAP_W-1:0] adapt;
    logic [TAP_W-1:0] applied;
    logic [TAP_W-1:0] taps_out;
    logic [8:0]       range_mv;
    logic             eye_pwr;
    logic             dfe_go, ctle_go, cdr_rst;
  } rte_state_t;

  localparam rte_state_t ST_RESET = '{
    r11: RST_EYE_CFG, r1e: RST_DFE_PWR, r23: RST_TAP_OVR,
    r3e: RST_LOCK_MON, r31: RST_ADAPT_MODE, r2a: RST_ACC_TIME,
    range_mv: RANGE_MV_0, eye_pwr: 1'h0, st: BUS_IDLE,
    default: '0};

  rte_state_t q, n;

  // ****************************************************
  // Helpers
  // ****************************************************
  // Range code to comparator span in mV
  function automatic logic [8:0] range_mv(input logic [1:0] c);
    case (c)
      2'h0:    range_mv = RANGE_MV_0;
      2'h1:    range_mv = RANGE_MV_1;
      2'h2:    range_mv = RANGE_MV_2;
      default: range_mv = RANGE_MV_3;
    endcase
  endfunction

  // Pack written tap registers into the tap bus
  function automatic logic [TAP_W-1:0] reg_taps(input rte_state_t s);
    reg_taps = {s.r12[BIT_TAP1_SIGN], s.r12[4:0],
                s.r11[0], s.r20[7:4], s.r11[1], s.r20[3:0],
                s.r11[2], s.r21[7:4], s.r11[3], s.r21[3:0]};
  endfunction

  // Observation byte for one tap: sign on bit 7, weight low
  function automatic logic [7:0] obs_byte(input logic [TAP_W-1:0] t,
                                          input logic [7:0] a);
    case (a)
      REG_OBS_ONE:   obs_byte = {t[25], 2'h0, t[24:20]};
      REG_OBS_TWO:   obs_byte = {t[19], 3'h0, t[18:15]};
      REG_OBS_THREE: obs_byte = {t[14], 3'h0, t[13:10]};
      REG_OBS_FOUR:  obs_byte = {t[9], 3'h0, t[8:5]};
      default:       obs_byte = {t[4], 3'h0, t[3:0]};
    endcase
  endfunction

  // ****************************************************
  // Next-state logic
  // ****************************************************
  always_comb begin
    logic             scl_rise, scl_fall, start_c, stop_c;
    logic             sel, wr_en, do_load, sweeping, cdr_evt;
    logic [7:0]       rd;
    logic [18:0]      limit;
    logic [TAP_W-1:0] man;
    scl_rise = 1'h0;
    scl_fall = 1'h0;
    start_c  = 1'h0;
    stop_c   = 1'h0;
    wr_en    = 1'h0;
    do_load  = 1'h0;
    rd       = 8'h00;
    sel      = 1'h0;
    sweeping = 1'h0;
    cdr_evt  = 1'h0;
    limit    = 19'h00000;
    man      = '0;
    n        = q;
    // Pin synchronisers
    n.scl_s1 = SCL_IN;
    n.scl_s2 = q.scl_s1;
    n.scl_s3 = q.scl_s2;
    n.sda_s1 = SDA_IN;
    n.sda_s2 = q.sda_s1;
    n.sda_s3 = q.sda_s2;
    n.sig_s1 = SIGNAL_DETECT_IN;
    n.sig_s2 = q.sig_s1;
    n.sig_s3 = q.sig_s2;
    n.dfe_go  = 1'h0;
    n.ctle_go = 1'h0;
    n.cdr_rst = 1'h0;
    scl_rise = q.scl_s2 & ~q.scl_s3;
    scl_fall = ~q.scl_s2 & q.scl_s3;
    start_c  = q.scl_s2 & q.scl_s3 & ~q.sda_s2 & q.sda_s3;
    stop_c   = q.scl_s2 & q.scl_s3 & q.sda_s2 & ~q.sda_s3;
    sel = q.rff[BIT_CH_EN] & (q.rff[1:0] == CH_ID);
    sweeping = q.r24[BIT_FAST_EN] & q.r24[BIT_SWEEP];

    // Two-wire slave: sample on SCL rise, drive on SCL fall
    if (start_c) begin
      n.st     = BUS_ADDR;
      n.bitc   = 4'h0;
      n.sda_oe = 1'h0;
    end else if (stop_c) begin
      n.st     = BUS_IDLE;
      n.sda_oe = 1'h0;
    end else begin
      case (q.st)
        BUS_IDLE: begin
          n.sda_oe = 1'h0;
        end
        BUS_ADDR, BUS_WBYTE: begin
          if (scl_rise) begin
            n.shreg = {q.shreg[6:0], q.sda_s2};
            n.bitc  = q.bitc + 4'h1;
          end else if (scl_fall && q.bitc == 4'h8) begin
            n.bitc = 4'h0;
            if (q.st == BUS_ADDR) begin
              n.rw      = q.shreg[0];
              n.got_ptr = 1'h0;
              n.sda_oe  = (q.shreg[7:1] == DEV_ADDR);
              n.st      = (q.shreg[7:1] == DEV_ADDR) ? BUS_ACK_A
                                                     : BUS_IDLE;
            end else begin
              n.sda_oe = 1'h1;
              n.st     = BUS_ACK_W;
              if (!q.got_ptr) begin
                n.ptr     = q.shreg;
                n.got_ptr = 1'h1;
              end else begin
                wr_en = 1'h1;
                n.ptr = q.ptr + 8'h01;
              end
            end
          end
        end
        BUS_ACK_A: begin
          if (scl_fall) begin
            n.bitc = 4'h0;
            if (q.rw) begin
              do_load = 1'h1;
              n.st    = BUS_RDATA;
            end else begin
              n.sda_oe = 1'h0;
              n.st     = BUS_WBYTE;
            end
          end
        end
        BUS_ACK_W: begin
          if (scl_fall) begin
            n.sda_oe = 1'h0;
            n.st     = BUS_WBYTE;
          end
        end
        BUS_RDATA: begin
          if (scl_fall) begin
            if (q.bitc == 4'h7) begin
              n.sda_oe = 1'h0;
              n.st     = BUS_MACK;
            end else begin
              n.shreg  = {q.shreg[6:0], 1'h0};
              n.sda_oe = ~q.shreg[6];
              n.bitc   = q.bitc + 4'h1;
            end
          end
        end
        BUS_MACK: begin
          if (scl_rise) begin
            n.nack = q.sda_s2;
          end else if (scl_fall) begin
            if (q.nack) begin
              n.st = BUS_IDLE;
            end else begin
              do_load = 1'h1;
              n.bitc  = 4'h0;
              n.st    = BUS_RDATA;
            end
          end
        end
        default: begin
          n.st     = BUS_IDLE;
          n.sda_oe = 1'h0;
        end
      endcase
    end

    // Eye error accumulation for the point in measurement
    limit = 19'(({11'h000, q.r2a} + 19'h00001) << ACC_SHIFT);
    if (sweeping && q.tcnt < limit) begin
      n.tcnt = q.tcnt + 19'h00001;
      if (EYE_HIT_IN && q.eye_pwr && q.acc != EYE_CNT_MAX) begin
        n.acc = q.acc + 16'h0001;
      end
    end

    // Read data fetch and its side effects
    if (do_load) begin
      if (q.ptr == REG_CH_SEL) begin
        rd = q.rff;
      end else if (sel) begin
        case (q.ptr)
          REG_CDR_RST:    rd = q.r0a;
          REG_EYE_CFG:    rd = q.r11;
          REG_TAP1:       rd = q.r12;
          REG_MAN_TAP:    rd = q.r15;
          REG_SLEW:       rd = q.r18;
          REG_DFE_PWR:    rd = q.r1e;
          REG_POLARITY:   rd = q.r1f;
          REG_TAP23:      rd = q.r20;
          REG_TAP45:      rd = q.r21;
          REG_EYE_OVR:    rd = q.r22;
          REG_TAP_OVR:    rd = q.r23;
          REG_FAST_EYE:   rd = q.r24;
          REG_ACC_TIME:   rd = q.r2a;
          REG_RATE_ADAPT: rd = q.r2f;
          REG_ADAPT_MODE: rd = q.r31;
          REG_LOCK_MON:   rd = q.r3e;
          REG_EYE_LO: begin
            rd        = q.lsb;
            n.lo_pend = 1'h0;
          end
          REG_EYE_UP: begin
            if (q.lo_pend) begin
              rd        = q.lsb;
              n.lo_pend = 1'h0;
            end else begin
              rd = q.cur[15:8];
              if (sweeping) begin
                n.lsb     = q.cur[7:0];
                // Warm-up point after start is sent as zero
                n.cur = (q.pidx == 13'h0000) ? 16'h0000 : q.acc;
                n.acc     = 16'h0000;
                n.tcnt    = 19'h00000;
                n.pidx    = q.pidx + 13'h0001;
                n.lo_pend = 1'h1;
              end
            end
          end
          REG_OBS_ONE, REG_OBS_TWO, REG_OBS_THREE, REG_OBS_FOUR,
          REG_OBS_FIVE: rd = obs_byte(q.applied, q.ptr);
          default:        rd = 8'h00;
        endcase
      end
      n.shreg  = rd;
      n.sda_oe = ~rd[7];
      n.ptr    = (q.ptr == REG_EYE_UP) ? q.ptr : q.ptr + 8'h01;
    end

    // Sweep ends once the last point's bytes are out
    if (sweeping && q.pidx == EYE_TOTAL_PTS && !q.lo_pend) begin
      n.r24[BIT_SWEEP] = 1'h0;
    end

    // Register writes and their triggers
    if (wr_en && q.ptr == REG_CH_SEL) begin
      n.rff = q.shreg;
    end else if (wr_en && sel) begin
      case (q.ptr)
        REG_CDR_RST: begin
          n.r0a     = q.shreg;
          n.cdr_rst = |q.shreg[BIT_CDR_LO+1:BIT_CDR_LO];
        end
        REG_EYE_CFG:  n.r11 = q.shreg;
        REG_TAP1:     n.r12 = q.shreg;
        REG_MAN_TAP:  n.r15 = q.shreg;
        REG_SLEW:     n.r18 = q.shreg;
        REG_DFE_PWR:  n.r1e = q.shreg;
        REG_POLARITY: n.r1f = q.shreg;
        REG_TAP23:    n.r20 = q.shreg;
        REG_TAP45:    n.r21 = q.shreg;
        REG_EYE_OVR:  n.r22 = q.shreg;
        REG_TAP_OVR:  n.r23 = q.shreg;
        REG_FAST_EYE: begin
          n.r24 = q.shreg;
          if (q.shreg[BIT_SWEEP] && !q.r24[BIT_SWEEP]) begin
            n.pidx    = 13'h0000;
            n.acc     = 16'h0000;
            n.tcnt    = 19'h00000;
            n.cur     = 16'h0000;
            n.lsb     = 8'h00;
            n.lo_pend = 1'h0;
          end
          n.dfe_go = q.r24[BIT_DFE_TRIG] & ~q.shreg[BIT_DFE_TRIG];
        end
        REG_ACC_TIME: n.r2a = q.shreg;
        REG_RATE_ADAPT: begin
          n.r2f     = q.shreg;
          n.ctle_go = q.r2f[BIT_CTLE_TRIG]
                      & ~q.shreg[BIT_CTLE_TRIG];
        end
        REG_ADAPT_MODE: n.r31 = q.shreg;
        REG_LOCK_MON:   n.r3e = q.shreg;
        default: ;
      endcase
    end

    // Recovery reset also on first signal while unlocked
    cdr_evt = n.cdr_rst | (q.sig_s2 & ~q.sig_s3 & ~LOCK_IN);
    n.cdr_rst = cdr_evt;
    if (cdr_evt && q.r31[BIT_MODE_LO+1:BIT_MODE_LO] >= MODE_DFE_MIN) begin
      n.dfe_go = 1'h1;
    end

    // Adapted taps: seed from registers, keep unless improved
    if (n.dfe_go) begin
      n.adapt = reg_taps(q);
    end else if (ADAPT_DONE_IN && ADAPT_BETTER_IN) begin
      n.adapt = ADAPT_TAPS_IN;
    end

    // Taps driven to the equalizer
    man = reg_taps(q);
    n.applied  = q.r15[BIT_MAN_TAP] ? man : q.adapt;
    n.taps_out = q.r1e[BIT_FEEDBACK_EQ_POWERDOWN] ? '0 : n.applied;
    n.range_mv = range_mv(q.r11[BIT_RANGE_LO+1:BIT_RANGE_LO]);
    n.eye_pwr  = ~q.r11[BIT_EYE_PD] | PERIODIC_POWER_IN;
  end

  // ****************************************************
  // State register
  // ****************************************************
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      q <= ST_RESET;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from state flops
  assign SDA_OUT          = q.nack & 1'h0;
  assign SDA_OE_OUT       = q.sda_oe;
  assign EYE_RANGE_MV_OUT = q.range_mv;
  assign EYE_POWER_OUT    = q.eye_pwr;
  assign LOCK_MON_EN_OUT  = q.r3e[BIT_LOCK_MON];
  assign EYE_OVR_OUT      = q.r22[BIT_EYE_OVR];
  assign FAST_EYE_OUT     = q.r24[BIT_FAST_EN];
  assign EYE_PHASE_OUT    = q.pidx[11:6];
  assign EYE_VOLT_OUT     = q.pidx[5:0];
  assign TAP_OVR_OUT      = q.r23[BIT_TAP_OVR];
  assign FEEDBACK_EQ_POWERDOWN_OUT       = q.r1e[BIT_FEEDBACK_EQ_POWERDOWN];
  assign DFE_TAPS_OUT     = q.taps_out;
  assign DFE_ADAPT_OUT    = q.dfe_go;
  assign CTLE_ADAPT_OUT   = q.ctle_go;
  assign CDR_RESET_OUT    = q.cdr_rst;
  assign OUT_INVERT_OUT   = q.r1f[BIT_INVERT];
  assign SLOW_SLEW_OUT    = q.r18[BIT_SLOW_SLEW];
  assign ADAPT_MODE_OUT   = q.r31[BIT_MODE_LO+1:BIT_MODE_LO];

  // ****************************************************
  // Assertions
  // ****************************************************
  // Assertion helpers
  logic scl_fall_w, sel_w, sweeping_w;
  assign scl_fall_w = ~q.scl_s2 & q.scl_s3;
  assign sel_w      = q.rff[BIT_CH_EN] & (q.rff[1:0] == CH_ID);
  assign sweeping_w = q.r24[BIT_FAST_EN] & q.r24[BIT_SWEEP];

  default clocking dc @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  a_range_map: assert property (
    ##1 EYE_RANGE_MV_OUT == range_mv($past(q.r11[7:6])))
    else $error("eye range span wrong");
  a_eye_power: assert property (
    !q.r11[BIT_EYE_PD] |=> EYE_POWER_OUT)
    else $error("eye monitor not powered");
  a_taps_off: assert property (
    q.r1e[BIT_FEEDBACK_EQ_POWERDOWN] |=> DFE_TAPS_OUT == '0)
    else $error("taps applied while powered down");
  a_manual_taps: assert property (
    q.r15[BIT_MAN_TAP] && !q.r1e[BIT_FEEDBACK_EQ_POWERDOWN]
    |=> DFE_TAPS_OUT == $past(reg_taps(q)))
    else $error("manual taps not applied");
  a_keep_start: assert property (
    !n.dfe_go && !(ADAPT_DONE_IN && ADAPT_BETTER_IN) |=> $stable(q.adapt))
    else $error("starting taps lost");
  a_ctle_trig: assert property (
    $fell(q.r2f[BIT_CTLE_TRIG]) |-> CTLE_ADAPT_OUT)
    else $error("linear adaptation not started");
  a_step_point: assert property (
    q.st == BUS_ACK_A && q.rw && scl_fall_w && sel_w && sweeping_w
    && q.ptr == REG_EYE_UP && !q.lo_pend
    |=> q.acc == 16'h0000 && q.pidx == $past(q.pidx) + 13'h0001)
    else $error("upper byte read did not step");
  a_hold_point: assert property (
    q.lo_pend && $stable(q.st) |=> $stable(q.cur) || !q.lo_pend)
    else $error("point loaded before both bytes read");
  a_sweep_end: assert property (
    sweeping_w && q.pidx == EYE_TOTAL_PTS && !q.lo_pend
    |=> !q.r24[BIT_SWEEP])
    else $error("sweep start bit not cleared");
  a_dfe_mode: assert property (
    CDR_RESET_OUT && q.r31[6:5] >= MODE_DFE_MIN |-> DFE_ADAPT_OUT)
    else $error("tap adaptation missed on reset");

  c_sweep_done: cover property ($fell(q.r24[BIT_SWEEP]));
  c_stream_lsb: cover property (q.lo_pend ##[1:400] !q.lo_pend);
  c_adapt_better: cover property (ADAPT_DONE_IN && ADAPT_BETTER_IN);

endmodule

// file: verification/rte_host_model.sv
`timescale 1ns/1ns
// ****************************************************
// Two-wire host controller, 400 ns bit slot
// ****************************************************
module rte_host_model (
  input  wire logic SDA_OE_IN,
  output logic      SCL_OUT,
  output logic      SDA_OUT
);
  logic drv;

  // Pulled-up wire: released level is high, either party pulls low
  assign SDA_OUT = drv & ~SDA_OE_IN;

  // Bus idle at time zero
  initial begin
    drv = 1'b1;
    SCL_OUT = 1'b1;
  end

  // One bit: data set while clock low, sampled mid high phase
  task automatic bit_x(input logic b, output logic r);
    drv = b;
    #100 SCL_OUT = 1'b1;
    #100 r = SDA_OUT;
    #100 SCL_OUT = 1'b0;
    #100;
  endtask

  // Start or repeated start
  task automatic go();
    drv = 1'b1;
    #100 SCL_OUT = 1'b1;
    #100 drv = 1'b0;
    #100 SCL_OUT = 1'b0;
    #100;
  endtask

  // Stop, clock then stands still high
  task automatic halt();
    drv = 1'b0;
    #100 SCL_OUT = 1'b1;
    #100 drv = 1'b1;
    #200;
  endtask

  // Eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ackm,
                      output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(ackm, ack);
  endtask
endmodule

// file: verification/retimer_eye_and_tap_ctrl_bench.sv
`timescale 1ns/1ns
module retimer_eye_and_tap_ctrl_bench;
  import rte_pkg::*;
  logic             clk_in = 1'b0;
  logic             rst_in = 1'b1;
  logic             pper   = 1'b0;
  logic             sdet   = 1'b0;
  logic             scl, sda, oe, pwr, lmon, fast, inv, dfe_p, ctle_p, cdr_p;
  logic [8:0]       mv;
  logic [TAP_W-1:0] taps;
  logic [TAP_W-1:0] a_taps = '0;
  logic             a_done = 1'b0, a_bet = 1'b0, eovr, tovr, dpd;
  logic [5:0]       ph, vo;
  logic [1:0]       amode;
  logic [7:0]       rb [8];
  logic [7:0]       regs [8] = '{8'h11, 8'h1E, 8'h23, 8'h3E, 8'h31, 8'h22,
                                 8'h15, 8'h12};
  logic [7:0]       rstv [8] = '{8'h20, 8'h08, 8'h40, 8'h80, 8'h20, 8'h00,
                                 8'h00, 8'h00};
  int               n_fail = 0, checks = 0, cyc = 0;
  int               n_dfe = 0, n_ctle = 0, n_cdr = 0;

  always #25 clk_in = ~clk_in;

  rte_host_model h (.SDA_OE_IN(oe), .SCL_OUT(scl), .SDA_OUT(sda));

  rte_eye_tap_ctrl #(.ACC_SHIFT(2)) dut (
    .CLK_IN(clk_in), .RST_IN(rst_in), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(), .SDA_OE_OUT(oe), .EYE_HIT_IN(1'b1),
    .PERIODIC_POWER_IN(pper), .SIGNAL_DETECT_IN(sdet), .LOCK_IN(1'b0),
    .ADAPT_DONE_IN(a_done), .ADAPT_BETTER_IN(a_bet), .ADAPT_TAPS_IN(a_taps),
    .EYE_RANGE_MV_OUT(mv), .EYE_POWER_OUT(pwr), .LOCK_MON_EN_OUT(lmon),
    .EYE_OVR_OUT(eovr), .FAST_EYE_OUT(fast), .EYE_PHASE_OUT(ph),
    .EYE_VOLT_OUT(vo), .TAP_OVR_OUT(tovr), .FEEDBACK_EQ_POWERDOWN_OUT(dpd),
    .DFE_TAPS_OUT(taps),
    .DFE_ADAPT_OUT(dfe_p), .CTLE_ADAPT_OUT(ctle_p), .CDR_RESET_OUT(cdr_p),
    .OUT_INVERT_OUT(inv), .SLOW_SLEW_OUT(), .ADAPT_MODE_OUT(amode));

  // Pulse counters and hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    n_dfe <= n_dfe + int'(dfe_p);
    n_ctle <= n_ctle + int'(ctle_p);
    n_cdr <= n_cdr + int'(cdr_p);
    if (cyc == 30000) begin
      n_fail = n_fail + 1;
      summarize();
    end
  end

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] r, logic [7:0] d);
    logic [7:0] x;
    logic       k;
    h.go();
    h.xfer(8'h30, 1'b1, x, k);
    h.xfer(r, 1'b1, x, k);
    h.xfer(d, 1'b1, x, k);
    h.halt();
    chk("ack", 0, k);
  endtask

  // Read n bytes from one pointer, host nacks the last
  task automatic rd(logic [7:0] r, int n);
    logic [7:0] x;
    logic       k;
    h.go();
    h.xfer(8'h30, 1'b1, x, k);
    h.xfer(r, 1'b1, x, k);
    h.go();
    h.xfer(8'h31, 1'b1, x, k);
    for (int i = 0; i < n; i++) begin
      h.xfer(8'hFF, i == n - 1, rb[i], k);
    end
    h.halt();
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************************
  // Test sequence
  // ****************************************************
  initial begin
    repeat (5) @(posedge clk_in);
    @(negedge clk_in) rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    wr(REG_CH_SEL, 8'h05);
    rd(REG_EYE_CFG, 1);
    chk("other channel", 8'h00, rb[0]);
    wr(REG_CH_SEL, 8'h04);
    for (int i = 0; i < 8; i++) begin
      rd(regs[i], 1);
      chk("reset value", rstv[i], rb[0]);
    end
    chk("eye override", 0, eovr);
    chk("tap override", 1, tovr);
    $display("test reset values done");
    for (int k = 0; k < 4; k++) begin
      wr(REG_EYE_CFG, 8'(k << 6));
      chk("range", 100 * (k + 1), mv);
      chk("eye power", 1, pwr);
    end
    wr(REG_EYE_CFG, 8'h20);
    chk("eye power", 0, pwr);
    pper = 1'b1;
    repeat (3) @(negedge clk_in);
    chk("eye power", 1, pwr);
    wr(REG_LOCK_MON, 8'h00);
    chk("lock monitor", 0, lmon);
    wr(REG_POLARITY, 8'h80);
    chk("invert", 1, inv);
    $display("test controls done");
    wr(REG_DFE_PWR, 8'h00);
    chk("dfe power", 0, dpd);
    wr(REG_MAN_TAP, 8'h80);
    wr(REG_TAP1, 8'h95);
    wr(REG_TAP23, 8'h55);
    wr(REG_TAP45, 8'h55);
    wr(REG_EYE_CFG, 8'h0F);
    chk("taps", {1'b1, 5'h15, {4{1'b1, 4'h5}}}, taps);
    rd(REG_OBS_ONE, 2);
    chk("observe one", 8'h95, rb[0]);
    chk("observe two", 8'h85, rb[1]);
    wr(REG_DFE_PWR, 8'h08);
    chk("taps off", 0, taps);
    $display("test taps done");
    wr(REG_RATE_ADAPT, 8'h01);
    chk("linear start", 0, n_ctle);
    wr(REG_RATE_ADAPT, 8'h00);
    chk("linear start", 1, n_ctle);
    rd(REG_OBS_ONE, 5);
    wr(REG_TAP1, rb[0]);
    wr(REG_TAP23, {rb[1][3:0], rb[2][3:0]});
    wr(REG_TAP45, {rb[3][3:0], rb[4][3:0]});
    wr(REG_EYE_CFG, {4'h0, rb[4][7], rb[3][7], rb[2][7], rb[1][7]});
    wr(REG_FAST_EYE, 8'h04);
    wr(REG_FAST_EYE, 8'h00);
    chk("tap start", 1, n_dfe);
    wr(REG_MAN_TAP, 8'h00);
    @(negedge clk_in) a_done = 1'b1;
    @(negedge clk_in) a_done = 1'b0;
    rd(REG_OBS_ONE, 1);
    chk("kept start", 8'h95, rb[0]);
    a_taps = 26'h0A00000;
    a_bet  = 1'b1;
    @(negedge clk_in) a_done = 1'b1;
    @(negedge clk_in) a_done = 1'b0;
    rd(REG_OBS_ONE, 1);
    chk("better taps", 8'h0A, rb[0]);
    wr(REG_ADAPT_MODE, 8'h40);
    chk("adapt mode", 2, amode);
    wr(REG_CDR_RST, 8'h04);
    chk("recovery reset", 1, n_cdr);
    chk("tap adapt", 2, n_dfe);
    sdet = 1'b1;
    repeat (8) @(negedge clk_in);
    chk("signal arrival", 2, n_cdr);
    chk("tap adapt", 3, n_dfe);
    wr(REG_ADAPT_MODE, 8'h20);
    wr(REG_CDR_RST, 8'h0C);
    chk("mode one", 3, n_dfe);
    $display("test adaptation done");
    wr(REG_ACC_TIME, 8'h00);
    wr(REG_FAST_EYE, 8'h82);
    chk("fast mode", 1, fast);
    rd(REG_EYE_UP, 8);
    for (int i = 0; i < 8; i++) begin
      chk("stream", (i > 3 && i % 2 == 1) ? 4 : 0, rb[i]);
    end
    rd(REG_EYE_UP, 1);
    chk("upper", 0, rb[0]);
    rd(REG_EYE_UP, 1);
    chk("resume", 4, rb[0]);
    rd(REG_EYE_UP, 1);
    chk("upper", 0, rb[0]);
    rd(REG_EYE_LO, 1);
    chk("lower", 4, rb[0]);
    chk("eye point", 12'h006, {ph, vo});
    wr(REG_FAST_EYE, 8'h00);
    chk("fast mode", 0, fast);
    $display("test eye done");
    summarize();
  end
endmodule
